// ===== core/idc_top.sv
// Instruction format decoder with an APB register slave.
`timescale 1ns/10ps
module idc_top
  import idc_pkg::*;
#(
  parameter int unsigned NUM_WREGS = 16
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory words.
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_word,
  output logic             fetch_ready,
  // Execution unit conditions and flag results.
  input  wire logic        cond_true,
  input  wire logic        skip_taken,
  input  wire logic        flag_update,
  input  wire logic [4:0]  flag_in,
  input  wire logic        zero_sticky,
  // Decoded instruction.
  output logic             instr_valid,
  output logic             exec_nop,
  output logic             two_word,
  output logic      [5:0]  instr_class,
  output logic      [1:0]  size_sel,
  output logic      [3:0]  base_work_reg,
  output logic      [3:0]  source_work_reg,
  output logic      [3:0]  dest_work_reg,
  output logic      [1:0]  src_mode,
  output logic      [1:0]  dest_mode,
  output logic      [12:0] file_addr,
  output logic             to_accumulator,
  output logic      [3:0]  bit_select_field,
  output logic      [22:0] operand,
  output logic      [1:0]  cycles,
  output logic      [4:0]  status_flags
);

  // The register file and layouts are sized for exactly sixteen registers.
  if (NUM_WREGS != FILE_OP_ACCUMULATOR_NUM) begin : g_chk
    $error("NUM_WREGS must be 16");
  end

  idc_state_t q;
  idc_state_t d;
  logic       take;
  logic [5:0] cls_in;

  // Only the three long forms need a second program word.
  function automatic logic is_dbl(input logic [5:0] c);
    is_dbl = (c == CL_CALL_L) || (c == CL_GOTO_L) || (c == CL_MOV_D); // [RULE9]
  endfunction

  assign take   = fetch_valid && q.fetch_rdy;
  assign cls_in = fetch_word[23:18]; // [RULE1]

  // Next-state logic: bus slave, flags, then the decoder.
  always_comb begin
    d        = q;
    d.vld    = 1'b0;
    d.nop    = (q.stall != 2'h0); // [RULE5]
    d.rdy    = 1'b0;
    d.slverr = 1'b0;
    if (q.stall != 2'h0) begin
      d.stall = q.stall - 2'h1;
    end
    // Setup of the answer; read data is captured at the same edge that raises pready.
    if (psel && penable && !q.rdy) begin
      d.rdy   = 1'b1;
      d.rdata = 32'h0;
      if (paddr == ADDR_CTRL) begin
        d.rdata[0] = q.en;
      end else if (paddr == ADDR_STATUS) begin
        d.rdata[4:0] = q.flags;
      end else if (paddr == ADDR_ERR) begin
        d.rdata[2:0] = q.err;
      end else if (paddr == ADDR_LAST) begin
        d.rdata[23:0] = q.last;
      end else if (paddr == ADDR_COUNT) begin
        d.rdata[15:0] = q.count;
      end else if (paddr[7:6] == FILE_OP_ACCUMULATOR_PAGE && paddr[1:0] == 2'h0) begin
        d.rdata[15:0] = q.wr[paddr[5:2]]; // [RULE15]
      end else begin
        d.slverr = 1'b1;
      end
    end
    // Writes land only at the edge where pready is sampled high.
    if (psel && penable && q.rdy && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        d.en = pwdata[0];
      end else if (paddr == ADDR_STATUS) begin
        d.flags = pwdata[4:0];
      end else if (paddr == ADDR_ERR) begin
        d.err = q.err & ~pwdata[2:0];
      end else if (paddr[7:6] == FILE_OP_ACCUMULATOR_PAGE && paddr[1:0] == 2'h0) begin
        d.wr[paddr[5:2]] = pwdata[15:0];
      end
    end
    // Hardware flag results override a software write in the same cycle.
    if (flag_update) begin
      d.flags = flag_in; // [RULE20]
      if (zero_sticky) begin
        d.flags[FLG_ZERO] = q.flags[FLG_ZERO] & flag_in[FLG_ZERO]; // [RULE20]
      end
    end
    // Decoder.
    if (take) begin
      d.last = fetch_word;
      case (q.st)
        ST_IDLE: begin
          d.vld   = 1'b1;
          d.two   = 1'b0;
          d.cls   = cls_in;
          d.size  = fetch_word[17:16]; // [RULE19]
          d.cyc   = CYC_ONE; // [RULE5]
          d.base  = fetch_word[15:12]; // [RULE10]
          d.dmode = fetch_word[11:10]; // [RULE10]
          d.dst   = fetch_word[9:6];
          d.smode = fetch_word[5:4]; // [RULE10]
          d.src   = fetch_word[3:0];
          d.faddr = fetch_word[12:0]; // [RULE14]
          d.facc  = !fetch_word[13]; // [RULE11]
          d.bsel  = fetch_word[15:12]; // [RULE13]
          d.oper  = 23'h0;
          case (cls_in)
            CL_CALL_L, CL_GOTO_L, CL_MOV_D: begin
              d.vld = 1'b0;
              d.st  = ST_WORD2; // [RULE2]
            end
            CL_BRANCH, CL_COMPUTED, CL_INDIRECT, CL_TABLE: begin
              d.cyc = CYC_TWO; // [RULE6]
            end
            CL_RETURN, CL_IRET: begin
              d.cyc = CYC_THREE; // [RULE6]
            end
            CL_BR_COND: begin
              d.cyc = cond_true ? CYC_TWO : CYC_ONE; // [RULE5]
            end
            CL_SKIP: begin
              if (skip_taken) begin
                d.vld = 1'b0;
                d.st  = ST_SKIP1; // [RULE7]
              end
            end
            CL_BIT: begin
              // Indirect form takes the bit number from the base register.
              d.base = fetch_word[7:4];
              d.bsel = fetch_word[11] ? q.wr[fetch_word[7:4]][3:0]
                                      : fetch_word[15:12]; // [RULE12]
            end
            CL_UNSIGNED_LITERAL_TEN: begin
              d.oper = {13'h0, fetch_word[13:4]};
              if (fetch_word[17:16] == SZ_BYTE && fetch_word[13:4] > UNSIGNED_LITERAL_TEN_BYTE_MAX) begin
                d.err[ERR_RANGE] = 1'b1; // [RULE16]
              end
            end
            CL_SIGNED_LITERAL_TEN: begin
              d.oper = {{13{fetch_word[13]}}, fetch_word[13:4]}; // [RULE18]
            end
            CL_SIGNED_LITERAL_SIXTEEN: begin
              d.oper = {{7{fetch_word[15]}}, fetch_word[15:0]}; // [RULE18]
            end
            default: begin
              // A lone second word has a zero opcode and decodes as a nop.
              d.cls = cls_in; // [RULE4]
            end
          endcase
          if (d.vld) begin
            d.stall = d.cyc - 2'h1;
          end
        end
        ST_WORD2: begin
          if (fetch_word[23:16] != OPC_ZERO) begin
            d.err[ERR_MSB] = 1'b1; // [RULE3]
          end
          d.vld  = 1'b1;
          d.two  = 1'b1;
          d.cyc  = CYC_TWO; // [RULE8]
          d.oper = {fetch_word[6:0], q.last[15:0]};
          if (q.last[0] && q.cls != CL_MOV_D) begin
            d.err[ERR_LSB] = 1'b1; // [RULE17]
          end
          d.st = ST_IDLE;
        end
        ST_SKIP1: begin
          // The skipped word is consumed as a nop cycle.
          d.nop = 1'b1;
          if (is_dbl(cls_in)) begin
            d.st = ST_SKIP2; // [RULE7]
          end else begin
            d.vld = 1'b1;
            d.cyc = CYC_TWO; // [RULE7]
            d.st  = ST_IDLE;
          end
        end
        default: begin
          d.nop = 1'b1;
          d.vld = 1'b1;
          d.cyc = CYC_THREE; // [RULE7]
          d.st  = ST_IDLE;
        end
      endcase
      if (d.vld) begin
        d.count = q.count + 16'h1;
      end
    end
    // Fetching stops while extra cycles run or while decoding is off.
    d.fetch_rdy = d.en && (d.stall == 2'h0);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs are taken straight from the state register.
  assign prdata           = q.rdata;
  assign pready           = q.rdy;
  assign pslverr          = q.slverr;
  assign fetch_ready      = q.fetch_rdy;
  assign instr_valid      = q.vld;
  assign exec_nop         = q.nop;
  assign two_word         = q.two;
  assign instr_class      = q.cls;
  assign size_sel         = q.size;
  assign base_work_reg    = q.base;
  assign source_work_reg  = q.src;
  assign dest_work_reg    = q.dst;
  assign src_mode         = q.smode;
  assign dest_mode        = q.dmode;
  assign file_addr        = q.faddr;
  assign to_accumulator   = q.facc;
  assign bit_select_field = q.bsel;
  assign operand          = q.oper;
  assign cycles           = q.cyc;
  assign status_flags     = q.flags;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_one_nop;
    exec_nop ##1 !exec_nop;
  endsequence
  sequence s_two_nop;
    exec_nop [*2] ##1 !exec_nop;
  endsequence

  word2_nop_a : assert property (take && q.st == ST_IDLE && fetch_word[23:16] == OPC_ZERO // [RULE4]
    |=> instr_valid && instr_class == CL_NOP && cycles == CYC_ONE)
    else $error("Lone second word did not decode as a nop.");
  dbl_fetch_a : assert property (take && q.st == ST_IDLE && is_dbl(cls_in) // [RULE2]
    |=> !instr_valid && q.st == ST_WORD2)
    else $error("Double-word first half was not held.");
  dbl_cyc_a : assert property (instr_valid && two_word |-> cycles == CYC_TWO && !exec_nop) // [RULE8]
    else $error("Double-word instruction cycle count wrong.");
  msb_err_a : assert property (take && q.st == ST_WORD2 && fetch_word[23:16] != OPC_ZERO // [RULE3]
    |=> q.err[ERR_MSB] && instr_valid)
    else $error("Second word upper bits not flagged.");
  extra_nop_a : assert property (instr_valid && !two_word && cycles == CYC_TWO // [RULE5]
    && q.st == ST_IDLE && !exec_nop |=> s_one_nop)
    else $error("Two-cycle instruction lacks one nop cycle.");
  three_cyc_a : assert property (instr_valid && cycles == CYC_THREE && !exec_nop // [RULE6]
    |=> s_two_nop)
    else $error("Three-cycle instruction lacks two nop cycles.");
  skip_three_a : assert property (take && q.st == ST_SKIP2 // [RULE7]
    |=> instr_valid && exec_nop && cycles == CYC_THREE)
    else $error("Skip over double word not three cycles.");
  sticky_zero_a : assert property (flag_update && zero_sticky && !flag_in[FLG_ZERO] // [RULE20]
    |=> !status_flags[FLG_ZERO])
    else $error("Sticky zero flag was set.");
  lit_lsb_a : assert property (take && q.st == ST_WORD2 && q.last[0] && q.cls != CL_MOV_D // [RULE17]
    |=> q.err[ERR_LSB])
    else $error("Odd program address not flagged.");

endmodule // idc_top

// ===== core/idc_pkg.sv
// Constants, state type and reset value for the instruction format decoder.
// Function
// RULE1 - A single instruction is a 24-bit word with an 8-bit opcode.
// RULE2 - A few double-word instructions span 48 bits over two fetched words.
// RULE3 - The second word of a double-word instruction has zero upper eight bits.
// RULE4 - A second word fetched on its own executes as a no-operation.
// RULE5 - Single-word takes one cycle; true condition or program change adds a nop cycle.
// RULE6 - Branches, indirect jumps, table ops and returns take two or three cycles.
// RULE7 - A taken skip takes two cycles, three over a double-word instruction.
// RULE8 - Double-word instructions execute in two cycles.
// RULE9 - Exactly three instructions occupy two program words; all others one.
// RULE10 - Three-operand ops take base, source with modifier, destination with modifier.
// RULE11 - File ops address a file register; result goes there or to accumulator.
// RULE12 - Bit ops take the bit from a literal or from a base register.
// RULE13 - The bit select field is four bits, positions 0 to 15.
// RULE14 - File register addresses cover 0000h to 1FFFh.
// RULE15 - Sixteen working registers serve as source, destination or base.
// RULE16 - The ten-bit literal is limited to 255 in byte mode.
// RULE17 - The 23-bit program address literal must have a zero LSB.
// RULE18 - Signed ten and sixteen bit literals decode as two's complement.
// RULE19 - Suffix selects byte, double, shadow or word; word is the default.
// RULE20 - Carry, digit carry, negative, overflow and sticky zero flags are kept.
package idc_pkg;

  // Word layout.
  localparam int unsigned WORD_W    = 24;
  localparam int unsigned FILE_OP_ACCUMULATOR_NUM  = 16;
  localparam logic [7:0]  OPC_ZERO  = 8'h00;
  // Instruction classes live in opcode bits 7:2, the size suffix in bits 1:0.
  localparam logic [5:0] CL_NOP      = 6'h00;
  localparam logic [5:0] CL_CALL_L   = 6'h01;
  localparam logic [5:0] CL_GOTO_L   = 6'h02;
  localparam logic [5:0] CL_MOV_D    = 6'h03;
  localparam logic [5:0] CL_BRANCH   = 6'h04;
  localparam logic [5:0] CL_BR_COND  = 6'h05;
  localparam logic [5:0] CL_COMPUTED = 6'h06;
  localparam logic [5:0] CL_INDIRECT = 6'h07;
  localparam logic [5:0] CL_TABLE    = 6'h08;
  localparam logic [5:0] CL_RETURN   = 6'h09;
  localparam logic [5:0] CL_IRET     = 6'h0a;
  localparam logic [5:0] CL_SKIP     = 6'h0b;
  localparam logic [5:0] CL_BIT      = 6'h12;
  localparam logic [5:0] CL_UNSIGNED_LITERAL_TEN    = 6'h13;
  localparam logic [5:0] CL_SIGNED_LITERAL_TEN   = 6'h14;
  localparam logic [5:0] CL_SIGNED_LITERAL_SIXTEEN   = 6'h15;
  // Size suffix encodings.
  localparam logic [1:0] SZ_WORD   = 2'h0;
  localparam logic [1:0] SZ_BYTE   = 2'h1;
  localparam logic [1:0] SZ_DOUBLE = 2'h2;
  localparam logic [1:0] SZ_SHADOW = 2'h3;
  // Cycle counts.
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [9:0] UNSIGNED_LITERAL_TEN_BYTE_MAX = 10'h0ff;
  // Register map.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR    = 8'h08;
  localparam logic [7:0] ADDR_LAST   = 8'h0c;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;
  localparam logic [1:0] FILE_OP_ACCUMULATOR_PAGE   = 2'h1;
  // Status flag and error bit positions.
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_DIGIT = 1;
  localparam int unsigned FLG_NEG   = 2;
  localparam int unsigned FLG_OVER  = 3;
  localparam int unsigned FLG_ZERO  = 4;
  localparam int unsigned ERR_MSB   = 0;
  localparam int unsigned ERR_RANGE = 1;
  localparam int unsigned ERR_LSB   = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WORD2 = 2'b01,
    ST_SKIP1 = 2'b11,
    ST_SKIP2 = 2'b10
  } idc_st_t;

  typedef struct packed {
    idc_st_t                       st;
    logic [1:0]                    stall;
    logic                          en;
    logic [4:0]                    flags;
    logic [2:0]                    err;
    logic [23:0]                   last;
    logic [15:0]                   count;
    logic [FILE_OP_ACCUMULATOR_NUM-1:0][15:0]     wr;
    logic                          rdy;
    logic [31:0]                   rdata;
    logic                          slverr;
    logic                          fetch_rdy;
    logic                          vld;
    logic                          nop;
    logic                          two;
    logic [5:0]                    cls;
    logic [1:0]                    size;
    logic [3:0]                    base;
    logic [3:0]                    src;
    logic [3:0]                    dst;
    logic [1:0]                    smode;
    logic [1:0]                    dmode;
    logic [12:0]                   faddr;
    logic                          facc;
    logic [3:0]                    bsel;
    logic [22:0]                   oper;
    logic [1:0]                    cyc;
  } idc_state_t;

  localparam idc_state_t STATE_RST = '0;

endpackage

// ===== test/idc_pmem.sv
// Program memory model handing up to three instruction words to the decoder.
`timescale 1ns/10ps
module idc_pmem (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Burst request from the bench.
  input  wire logic             go,
  input  wire logic             slow,
  input  wire logic [1:0]       n,
  input  wire logic [2:0][23:0] w,
  // Fetch handshake.
  input  wire logic             fetch_ready,
  output logic                  fetch_valid,
  output logic      [23:0]      fetch_word,
  output logic                  busy
);
  logic [1:0] idx;

  // A word stands until taken; a released bus shows the inverse so stale data never passes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_valid <= 1'b0;
      fetch_word  <= 24'h5a5a5a;
      idx         <= 2'h0;
      busy        <= 1'b0;
    end else if (fetch_valid && fetch_ready) begin
      idx  <= idx + 2'h1;
      busy <= (idx + 2'h1) != n;
      if ((idx + 2'h1) != n && !slow) begin
        fetch_word <= w[idx + 2'h1];
      end else begin
        fetch_valid <= 1'b0;
        fetch_word  <= ~fetch_word;
      end
    end else if (busy && !fetch_valid) begin
      fetch_valid <= 1'b1;
      fetch_word  <= w[idx];
    end else if (go && !busy) begin
      fetch_valid <= 1'b1;
      fetch_word  <= w[0];
      idx         <= 2'h0;
      busy        <= 1'b1;
    end
  end
endmodule // idc_pmem

// ===== test/cpu_instruction_format_decode_test.sv
// Self-checking bench for the instruction format decoder.
`timescale 1ns/10ps
module cpu_instruction_format_decode_test import idc_pkg::*;;
  logic             pclk = 1'b0;
  logic             presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             fetch_valid, fetch_ready, cond_true, skip_taken;
  logic             flag_update, zero_sticky, go, slow, busy;
  logic [23:0]      fetch_word;
  logic [4:0]       flag_in, status_flags;
  logic             instr_valid, exec_nop, two_word, to_accumulator;
  logic [5:0]       instr_class;
  logic [1:0]       size_sel, src_mode, dest_mode, cycles, n;
  logic [3:0]       base_work_reg, source_work_reg, dest_work_reg, bit_select_field;
  logic [12:0]      file_addr;
  logic [22:0]      operand;
  logic [2:0][23:0] w;
  int               fails = 0, n_tests = 0, nv = 0, ne = 0, tick = 0;

  idc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fetch_valid, .fetch_word, .fetch_ready, .cond_true, .skip_taken,
    .flag_update, .flag_in, .zero_sticky, .instr_valid, .exec_nop, .two_word, .instr_class,
    .size_sel, .base_work_reg, .source_work_reg, .dest_work_reg, .src_mode, .dest_mode,
    .file_addr, .to_accumulator, .bit_select_field, .operand, .cycles, .status_flags);
  idc_pmem pm (.pclk, .presetn, .go, .slow, .n, .w, .fetch_ready, .fetch_valid, .fetch_word,
    .busy);

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  // Count decode pulses and nop cycles; a hung run is cut short here.
  always @(posedge pclk) begin
    tick++;
    if (instr_valid === 1'b1) nv++;
    if (exec_nop === 1'b1) ne++;
    if (tick == 8000) begin
      fails++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [23:0] wd(input logic [5:0] c, input logic [1:0] s,
                                     input logic [15:0] lo);
    return {c, s, lo};
  endfunction

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask

  // Hand k words to the memory model and wait until the decoder has drained them.
  task automatic run(input logic [23:0] a, b, c, input logic [1:0] k);
    int t;
    @(posedge pclk);
    w  <= {c, b, a};
    n  <= k;
    go <= 1'b1;
    nv = 0;
    ne = 0;
    @(posedge pclk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (busy === 1'b1 && t < 60);
    repeat (5) @(posedge pclk);
  endtask

  task automatic t_regs;
    apb(0, ADDR_CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(0, 8'h20, 0);
    chk("unmapped err", 1, err);
    apb(1, ADDR_CTRL, 1);
    apb(1, 8'h7c, 32'h1234);
    apb(0, 8'h7c, 0);
    chk("wreg15", 32'h1234, rd);
  endtask

  task automatic t_lit;
    run(wd(CL_UNSIGNED_LITERAL_TEN, SZ_BYTE, 16'h0ff0), 0, 0, 1);
    chk("valid count", 1, nv);
    chk("cycles", CYC_ONE, cycles);
    chk("lit byte", 32'hff, operand);
    run(wd(CL_UNSIGNED_LITERAL_TEN, SZ_BYTE, 16'h1000), 0, 0, 1);
    apb(0, ADDR_ERR, 0);
    chk("err range", 2, rd);
    apb(1, ADDR_ERR, 7);
    run(wd(CL_UNSIGNED_LITERAL_TEN, SZ_WORD, 16'h3ff0), 0, 0, 1);
    chk("lit word", 32'h3ff, operand);
    apb(0, ADDR_ERR, 0);
    chk("err clear", 0, rd);
    for (int s = 0; s < 4; s++) begin
      run(wd(CL_UNSIGNED_LITERAL_TEN, 2'(s), 16'h0001), 0, 0, 1);
      chk("size", s, size_sel);
    end
    run(wd(CL_SIGNED_LITERAL_TEN, SZ_WORD, 16'h2000), 0, 0, 1);
    chk("signed_literal_ten", 32'h7ffe00, operand);
    run(wd(CL_SIGNED_LITERAL_SIXTEEN, SZ_WORD, 16'h8000), 0, 0, 1);
    chk("signed_literal_sixteen", 32'h7f8000, operand);
  endtask

  task automatic t_ctrl;
    logic [5:0] cl [6] = '{CL_BRANCH, CL_COMPUTED, CL_INDIRECT, CL_TABLE, CL_RETURN, CL_IRET};
    for (int i = 0; i < 6; i++) begin
      run(wd(cl[i], SZ_WORD, 16'h0), 0, 0, 1);
      chk("ctrl cycles", (i > 3) ? 3 : 2, cycles);
      chk("nop cycles", (i > 3) ? 2 : 1, ne);
    end
    for (int i = 0; i < 2; i++) begin
      cond_true <= 1'(i);
      run(wd(CL_BR_COND, SZ_WORD, 16'h0), 0, 0, 1);
      chk("cond cycles", 1 + i, cycles);
    end
    cond_true <= 1'b0;
  endtask

  // Double-word forms, a lone second word, and the two format faults.
  task automatic t_double;
    logic [5:0] cl [3] = '{CL_CALL_L, CL_GOTO_L, CL_MOV_D};
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 1);
      run(wd(cl[i], SZ_WORD, 16'h1234), 24'h000056, 0, 2);
      chk("valid count", 1, nv);
      chk("two word", 1, two_word);
      chk("dw cycles", CYC_TWO, cycles);
      chk("dw operand", 32'h561234, operand);
    end
    slow <= 1'b0;
    run(24'h000056, 0, 0, 1);
    chk("lone class", CL_NOP, instr_class);
    chk("lone two word", 0, two_word);
    apb(0, ADDR_LAST, 0);
    chk("last word", 32'h000056, rd);
    run(wd(CL_GOTO_L, SZ_WORD, 16'h1235), 24'h000056, 0, 2);
    apb(0, ADDR_ERR, 0);
    chk("err odd", 4, rd);
    apb(1, ADDR_ERR, 7);
    run(wd(CL_GOTO_L, SZ_WORD, 16'h1234), 24'h010056, 0, 2);
    apb(0, ADDR_ERR, 0);
    chk("err msb", 1, rd);
    apb(1, ADDR_ERR, 7);
  endtask

  task automatic t_skip;
    skip_taken <= 1'b1;
    run(wd(CL_SKIP, SZ_WORD, 16'h0), wd(CL_UNSIGNED_LITERAL_TEN, SZ_WORD, 16'h5), 0, 2);
    chk("skip count", 1, nv);
    chk("skip single", CYC_TWO, cycles);
    run(wd(CL_SKIP, SZ_WORD, 16'h0), wd(CL_GOTO_L, SZ_WORD, 16'h1234), 24'h000056, 3);
    chk("skip double", CYC_THREE, cycles);
    skip_taken <= 1'b0;
  endtask

  task automatic t_fields;
    run(wd(CL_SIGNED_LITERAL_SIXTEEN, SZ_WORD, 16'hf5be), 0, 0, 1);
    chk("regs", 12'hfe6, {base_work_reg, source_work_reg, dest_work_reg});
    chk("modes", 4'hd, {src_mode, dest_mode});
    chk("file", {13'h15be, 1'b0}, {file_addr, to_accumulator});
    run(wd(CL_SIGNED_LITERAL_SIXTEEN, SZ_WORD, 16'h1fff), 0, 0, 1);
    chk("file top", {13'h1fff, 1'b1}, {file_addr, to_accumulator});
    run(wd(CL_BIT, SZ_WORD, 16'hb003), 0, 0, 1);
    chk("bit literal", 4'hb, bit_select_field);
    apb(1, 8'h4c, 32'h1e);
    run(wd(CL_BIT, SZ_WORD, 16'h0830), 0, 0, 1);
    chk("bit indirect", 4'he, bit_select_field);
  endtask

  // Load the flags; with the sticky input the zero flag can only be cleared.
  task automatic t_flag(input logic [4:0] f, input logic s, input logic [4:0] e);
    @(posedge pclk);
    flag_in     <= f;
    zero_sticky <= s;
    flag_update <= 1'b1;
    @(posedge pclk);
    flag_update <= 1'b0;
    @(posedge pclk);
    chk("flags", e, status_flags);
  endtask

  // A reset with no burst in flight must stop fetching and clear the working registers.
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset ready", 0, fetch_ready);
    apb(0, 8'h7c, 0);
    chk("reset wreg15", 0, rd);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cond_true, skip_taken, flag_update, zero_sticky, flag_in} = '0;
    {go, slow, n, w} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_lit;
    t_ctrl;
    t_double;
    t_skip;
    t_fields;
    t_flag(5'h1f, 1'b0, 5'h1f);
    t_flag(5'h0f, 1'b1, 5'h0f);
    t_flag(5'h10, 1'b1, 5'h00);
    apb(0, ADDR_STATUS, 0);
    chk("status reg", 0, rd);
    t_reset;
    wrap_up;
  end
endmodule // cpu_instruction_format_decode_test
